// *** design/pulse_counter_pkg.sv ***
// Package: register map, field positions, reset values and timing constants
package pulse_counter_pkg;
   // ==========================================================
   // Register indices (byte address = 4 * index)
   localparam int REG_CNT_HI = 0;
   localparam int REG_CNT_LO = 1;
   localparam int REG_PERIOD = 2;
   localparam int REG_CMP_HI = 3;
   localparam int REG_CMP_LO = 4;
   localparam int REG_CTRL = 5;
   localparam int REG_INCFG = 6;
   localparam int REG_INLVL = 7;
   localparam int REG_INT_STAT = 8;
   localparam int REG_INT_MASK = 9;
   localparam int REG_LAST = 9;
   // ==========================================================
   // Field positions
   localparam int CTRL_CMP_IRQ_EN = 11;
   localparam int CTRL_TIMER_MODE = 13;
   localparam int CTRL_CLR_ON_IRQ = 14;
   localparam int INCFG_Z_NEG = 11;
   localparam int EV_CMP = 0;
   localparam int EV_PERIOD = 1;
   localparam int EV_MARKER = 2;
   localparam int EV_W = 3;
   // ==========================================================
   // Reset values
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Timing: rates in Hz, cycle counts derived from the 100 MHz clock
   localparam int CLK_HZ = 100_000_000;
   localparam int TIMER_CLK_HZ = 250_000;
   localparam int PERIODIC_HZ = 200_000;
   localparam int TIMER_CLK_CYC = CLK_HZ / TIMER_CLK_HZ;
   localparam int PERIODIC_CYC = CLK_HZ / PERIODIC_HZ;
endpackage

// *** design/enc_link_if.sv ***
// Interface: decoded encoder events from the decoder to the counter core
interface enc_link_if;
   logic up;
   logic down;
   logic marker;
   logic [2:0] level;
   modport src (output up, output down, output marker, output level);
   modport dst (input up, input down, input marker, input level);
endinterface

// *** design/tick_divider.sv ***
// Module: divides the clock into a one-cycle enable pulse every DIV cycles
module tick_divider #(
   parameter int DIV = 400
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Enable pulse
   output logic tick
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt;
   wire wrap = (cnt == LAST);

   // ==========================================================
   // Free-running count; tick marks the wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= wrap ? '0 : cnt + 1'b1;
         tick <= wrap;
      end
   end
endmodule

// *** design/quad_decoder.sv ***
// Module: synchronises encoder pins and decodes quadrature steps and marker
module quad_decoder (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins, asynchronous to aclk
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic marker_pin,
   // Marker polarity, 1 = active low
   input wire logic z_neg,
   // Decoded events
   enc_link_if.src link
);
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [1:0] ab_q;
   logic z_q;

   // Forward order of {b,a}: 00 01 11 10
   wire [1:0] ab = sync2[1:0];
   wire [3:0] tr = {ab_q, ab};
   wire fwd = (tr == 4'h1) | (tr == 4'h7) | (tr == 4'hE) | (tr == 4'h8);
   wire rev = (tr == 4'h2) | (tr == 4'hB) | (tr == 4'hD) | (tr == 4'h4);
   wire z_act = sync2[2] ^ z_neg;

   // ==========================================================
   // Two-stage synchroniser, then edge decode at full clock rate
   // Every edge is seen at 100 MHz, far beyond the 150 kHz input limit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         ab_q <= 2'h0;
         z_q <= 1'b0;
      end else begin
         sync1 <= {marker_pin, phase_b, phase_a};
         sync2 <= sync1;
         ab_q <= ab;
         z_q <= z_act;
      end
   end

   // ==========================================================
   // Outputs to the counter core
   assign link.up = fwd;
   assign link.down = rev;
   assign link.marker = z_act & ~z_q;
   assign link.level = sync2;
endmodule

// *** design/pulse_counter_config_logic.sv ***
// Module: pulse counter core with comparator, timers and AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module pulse_counter_config_logic
   import pulse_counter_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 24
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Encoder pins
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic marker_pin,
   // Interrupt
   output logic irq
);
   localparam int HI_W = CNT_W - 16;

   // ==========================================================
   // State
   logic [CNT_W-1:0] count;
   logic [HI_W-1:0] load_hi;
   logic [HI_W-1:0] cmp_hi;
   logic [15:0] cmp_lo;
   logic [15:0] period;
   logic [15:0] period_cnt;
   logic [15:0] ctrl;
   logic [15:0] incfg;
   logic [EV_W-1:0] int_stat;
   logic [EV_W-1:0] int_mask;
   logic cmp_arm_q;
   logic [ADDR_W-1:0] aw_addr;
   logic aw_have;
   logic [15:0] w_data;
   logic [1:0] w_be;
   logic w_have;

   enc_link_if link ();
   logic tick_timer;
   logic tick_period;

   // ==========================================================
   // Submodules: pin decoder and the two rate dividers
   quad_decoder u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase_a(phase_a),
      .phase_b(phase_b),
      .marker_pin(marker_pin),
      .z_neg(incfg[INCFG_Z_NEG]),
      .link(link.src)
   );

   tick_divider #(.DIV(TIMER_CLK_CYC)) u_timer_clk (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick_timer)
   );

   tick_divider #(.DIV(PERIODIC_CYC)) u_periodic_clk (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick_period)
   );

   // ==========================================================
   // Write channel decode: address and data may arrive in either order
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_have & w_have & ~s_axi_bvalid;
   wire [3:0] wr_idx = aw_addr[5:2];
   wire wr_hit = (aw_addr[ADDR_W-1:6] == '0) & (wr_idx <= 4'(REG_LAST));
   wire [15:0] be_mask = {{8{w_be[1]}}, {8{w_be[0]}}};
   wire wr_ok = do_write & wr_hit;
   wire wr_cnt_hi = wr_ok & (wr_idx == 4'(REG_CNT_HI));
   wire wr_cnt_lo = wr_ok & (wr_idx == 4'(REG_CNT_LO));
   wire wr_period = wr_ok & (wr_idx == 4'(REG_PERIOD));
   wire wr_cmp_hi = wr_ok & (wr_idx == 4'(REG_CMP_HI));
   wire wr_cmp_lo = wr_ok & (wr_idx == 4'(REG_CMP_LO));
   wire wr_ctrl = wr_ok & (wr_idx == 4'(REG_CTRL));
   wire wr_incfg = wr_ok & (wr_idx == 4'(REG_INCFG));
   wire wr_stat = wr_ok & (wr_idx == 4'(REG_INT_STAT));
   wire wr_mask = wr_ok & (wr_idx == 4'(REG_INT_MASK));

   // Byte-lane merge of the staged write word into a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   // ==========================================================
   // Events: compare, periodic scan and marker
   wire [CNT_W-1:0] cmp_val = {cmp_hi, cmp_lo};
   wire cmp_arm = (count == cmp_val) & ctrl[CTRL_CMP_IRQ_EN];
   wire ev_cmp = cmp_arm & ~cmp_arm_q;
   wire period_on = (period != 16'h0000);
   wire ev_period = tick_period & period_on & (period_cnt == period - 16'h0001);
   wire [EV_W-1:0] events = {link.marker, ev_period, ev_cmp};
   wire [EV_W-1:0] stat_clr = wr_stat ? (w_data[EV_W-1:0] & {EV_W{w_be[0]}}) : '0;
   // Set wins over a same-cycle clear
   wire [EV_W-1:0] next_int_stat = (int_stat & ~stat_clr) | events;
   wire raise = |(events & int_mask);

   // ==========================================================
   // Counter next value: software load, then clear on interrupt, then count
   // Timer mode ignores the encoder and counts the 250 kHz enable
   wire timer_mode = ctrl[CTRL_TIMER_MODE];
   wire step_up = timer_mode ? tick_timer : link.up;
   wire step_dn = ~timer_mode & link.down;
   wire [15:0] load_lo = merge(count[15:0], w_data, be_mask);
   wire clr_irq = ctrl[CTRL_CLR_ON_IRQ] & raise;
   wire [CNT_W-1:0] next_count =
      wr_cnt_lo ? {load_hi, load_lo} :
      clr_irq ? '0 :
      step_up ? count + 1'b1 :
      step_dn ? count - 1'b1 :
      count;

   // ==========================================================
   // Counter, comparator and pending high byte of a counter load
   // A pair write must go high word first: the low word commits both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         load_hi <= '0;
         cmp_hi <= '0;
         cmp_lo <= REG_RESET;
         cmp_arm_q <= 1'b0;
      end else begin
         count <= next_count;
         cmp_arm_q <= cmp_arm;
         if (wr_cnt_hi && w_be[0]) begin
            load_hi <= w_data[HI_W-1:0];
         end
         if (wr_cmp_hi && w_be[0]) begin
            cmp_hi <= w_data[HI_W-1:0];
         end
         if (wr_cmp_lo) begin
            cmp_lo <= merge(cmp_lo, w_data, be_mask);
         end
      end
   end

   // ==========================================================
   // Control, configuration and scan period registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= REG_RESET;
         incfg <= REG_RESET;
         period <= REG_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= merge(ctrl, w_data, be_mask);
         end
         if (wr_incfg) begin
            incfg <= merge(incfg, w_data, be_mask);
         end
         if (wr_period) begin
            period <= merge(period, w_data, be_mask);
         end
      end
   end

   // ==========================================================
   // Scan period counter in 200 kHz ticks; a new period restarts it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_cnt <= REG_RESET;
      end else if (wr_period || ev_period || !period_on) begin
         period_cnt <= REG_RESET;
      end else if (tick_period) begin
         period_cnt <= period_cnt + 16'h0001;
      end
   end

   // ==========================================================
   // Interrupt status, mask and the registered level output
   // An unmasked status bit left set keeps the line high, so no new edge reaches software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_stat <= '0;
         int_mask <= '0;
         irq <= 1'b0;
      end else begin
         int_stat <= next_int_stat;
         if (wr_mask && w_be[0]) begin
            int_mask <= w_data[EV_W-1:0];
         end
         irq <= |(next_int_stat & int_mask);
      end
   end

   // ==========================================================
   // Write channel handshakes and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= REG_RESET;
         w_be <= 2'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_hs) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
            aw_have <= 1'b1;
         end else if (!aw_have && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (w_hs) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata[15:0];
            w_be <= s_axi_wstrb[1:0];
            w_have <= 1'b1;
         end else if (!w_have && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read selection; high words read the sign-extended top byte
   wire [3:0] rd_idx = s_axi_araddr[5:2];
   wire rd_hit = (s_axi_araddr[ADDR_W-1:6] == '0) & (rd_idx <= 4'(REG_LAST));
   wire [15:0] rd_word [0:REG_LAST];
   assign rd_word[REG_CNT_HI] = {{(16-HI_W){count[CNT_W-1]}}, count[CNT_W-1:16]};
   assign rd_word[REG_CNT_LO] = count[15:0];
   assign rd_word[REG_PERIOD] = period;
   assign rd_word[REG_CMP_HI] = {{(16-HI_W){cmp_hi[HI_W-1]}}, cmp_hi};
   assign rd_word[REG_CMP_LO] = cmp_lo;
   assign rd_word[REG_CTRL] = ctrl;
   assign rd_word[REG_INCFG] = incfg;
   assign rd_word[REG_INLVL] = {13'h0000, link.level};
   assign rd_word[REG_INT_STAT] = {{(16-EV_W){1'b0}}, int_stat};
   assign rd_word[REG_INT_MASK] = {{(16-EV_W){1'b0}}, int_mask};
   wire [15:0] rd_val = rd_hit ? rd_word[rd_idx] : 16'h0000;

   // ==========================================================
   // Read channel: one read under way, answer the cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (s_axi_rvalid && s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
            if (!s_axi_rvalid) begin
               s_axi_arready <= 1'b1;
            end
         end
      end
   end
endmodule

// *** dv/pulse_counter_config_logic_sva.sv ***
// Checker: bus handshake and reset relations seen at the top ports
module pulse_counter_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // One domain; reset mutes all but the reset check
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   rdata_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   reset_quiet_a: assert property (disable iff (1'h0) !aresetn |=>
      !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
endmodule

bind pulse_counter_config_logic pulse_counter_sva i_sva (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq
);

// *** dv/enc_model.sv ***
// Partner model: quadrature encoder and marker pin
module enc_model (
   // Clock
   input wire logic aclk,
   // Encoder pins
   output logic phase_a,
   output logic phase_b,
   output logic marker_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos = 0;
   // Pins idle low until the bench moves them
   initial begin
      phase_a = 1'h0;
      phase_b = 1'h0;
      marker_pin = 1'h0;
   end
   // ==========
   // Forward walks {b,a} 00,01,11,10; negative n walks back, one edge per gap
   task automatic step(input int n, input int gap);
      int d;
      d = (n < 0) ? -1 : 1;
      repeat ((n < 0) ? -n : n) begin
         pos = pos + d;
         phase_b <= pos[1];
         phase_a <= pos[1] ^ pos[0];
         repeat (gap) @(posedge aclk);
      end
   endtask
   // Marker held at a level; the caller picks which level is active
   task automatic mk(input logic lv, input int n);
      marker_pin <= lv;
      repeat (n) @(posedge aclk);
   endtask
endmodule

// *** dv/test_pulse_counter_config_logic.sv ***
// Testbench: register rows, counting, interrupts, timers and reset
module test_pulse_counter_config_logic
   import pulse_counter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic w; int i; logic [15:0] d;} row_t;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, pa, pb, pm;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] rv;
   int err_count = 0, checks = 0, cyc = 0, t0 = 0;
   // Edges that bready or rready wait, so that the stalled-response holds get exercised
   int lag = 0;
   // Writes then reads; pair reads show high half first
   row_t rows[13] = '{
      '{1'h1, 3, 16'hAB80}, '{1'h0, 3, 16'hFF80},
      '{1'h1, 4, 16'h1234}, '{1'h0, 4, 16'h1234},
      '{1'h1, 0, 16'h0080}, '{1'h1, 1, 16'h0001},
      '{1'h0, 0, 16'hFF80}, '{1'h0, 1, 16'h0001},
      '{1'h1, 9, 16'h0002}, '{1'h0, 9, 16'h0002},
      '{1'h1, 10, 16'h5555}, '{1'h0, 10, 16'h0000}, '{1'h0, 7, 16'h0000}};

   pulse_counter_config_logic i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .phase_a(pa), .phase_b(pb), .marker_pin(pm), .irq(irq));
   enc_model i_enc (.aclk(aclk), .phase_a(pa), .phase_b(pb), .marker_pin(pm));

   // ==========
   // Clock and a hang limit well past the expected run
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      checks++;
      if (v !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, v);
      end
   endtask
   // Indices past the map answer with an error
   function automatic logic [1:0] er(input int i);
      return (i > REG_LAST) ? RESP_SLVERR : RESP_OKAY;
   endfunction
   // ==========
   // Bus master: both write channels offered together, each dropped when taken
   task automatic wr(input int i, input logic [15:0] d);
      @(posedge aclk);
      awaddr <= 8'(i * 4);
      wdata <= {16'h0000, d};
      {awvalid, wvalid} <= 2'h3;
      bready <= (lag == 0);
      while (bvalid !== 1'h1 || bready !== 1'h1) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (lag > 0) lag--;
         if (lag == 0 && !bready) bready <= 1'h1;
      end
      chk("bresp", 32'(er(i)), 32'(bresp));
      bready <= 1'h0;
   endtask
   task automatic rd(input int i);
      @(posedge aclk);
      araddr <= 8'(i * 4);
      arvalid <= 1'h1;
      rready <= (lag == 0);
      while (rvalid !== 1'h1 || rready !== 1'h1) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (lag > 0) lag--;
         if (lag == 0 && !rready) rready <= 1'h1;
      end
      rv = rdata[15:0];
      chk("rresp", 32'(er(i)), 32'(rresp));
      chk("rdata_hi", 32'h0, 32'(rdata[31:16]));
      rready <= 1'h0;
   endtask
   task automatic rc(input int i, input logic [15:0] e);
      rd(i);
      chk("rdata", 32'(e), 32'(rv));
   endtask
   // Bounded wait for the interrupt level, then compare it
   task automatic wirq(input logic lv);
      int n;
      n = 0;
      while (irq !== lv && n < 3000) begin
         @(posedge aclk);
         n++;
      end
      chk("irq", 32'(lv), 32'(irq));
   endtask

   // ==========
   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rows[k]) begin
         if (rows[k].w) wr(rows[k].i, rows[k].d);
         else rc(rows[k].i, rows[k].d);
      end
      // Counting both ways at the top input rate, negative result sign-extends
      wr(0, 16'h0000);
      lag = 3;
      wr(1, 16'h0000);
      i_enc.step(5, 166);
      lag = 3;
      rc(1, 16'h0005);
      i_enc.step(-7, 166);
      rc(0, 16'hFFFF);
      rc(1, 16'hFFFE);
      // Comparator loaded before its interrupt is enabled, with clear on hit
      wr(9, 16'h0001);
      wr(3, 16'h0000);
      wr(4, 16'h0003);
      wr(0, 16'h0000);
      wr(1, 16'h0000);
      wr(5, 16'h4800);
      i_enc.step(3, 166);
      wirq(1'h1);
      rc(1, 16'h0000);
      rc(8, 16'h0001);
      wr(9, 16'h0000);
      wirq(1'h0);
      wr(9, 16'h0001);
      wirq(1'h1);
      wr(8, 16'h0001);
      wirq(1'h0);
      wr(5, 16'h0000);
      // Marker pulses of either polarity
      wr(8, 16'h0007);
      i_enc.mk(1'h1, 8);
      i_enc.mk(1'h0, 8);
      rc(8, 16'h0004);
      wr(6, 16'h0800);
      i_enc.mk(1'h1, 8);
      wr(8, 16'h0007);
      i_enc.mk(1'h0, 8);
      i_enc.mk(1'h1, 8);
      rc(8, 16'h0004);
      // Timer mode: 4000 cycles hold ten or eleven internal ticks
      wr(5, 16'h2000);
      wr(0, 16'h0000);
      wr(1, 16'h0000);
      repeat (4000) @(posedge aclk);
      rd(1);
      chk("timer", 32'h1, 32'(rv == 16'h000A || rv == 16'h000B));
      wr(5, 16'h0000);
      // Scan interrupt every two periodic ticks
      wr(9, 16'h0002);
      wr(8, 16'h0007);
      wr(2, 16'h0002);
      wirq(1'h1);
      t0 = cyc;
      wr(8, 16'h0002);
      wirq(1'h0);
      wirq(1'h1);
      chk("period", 32'h000003E8, 32'(cyc - t0));
      wr(2, 16'h0000);
      // Park pins at rest so release from reset sees no edge
      i_enc.step(3, 20);
      i_enc.mk(1'h0, 2);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      for (int k = 0; k <= REG_LAST; k++) begin
         if (k != REG_INLVL) rc(k, REG_RESET);
      end
      chk("irq", 32'h0, 32'(irq));
      results();
   end
endmodule
